// *** src/usbp_consts.svh ***
// usbp_consts.svh: offsets, bit positions, reset values and timing
// for the root hub port block. assumes a 10 MHz core clock.
`ifndef USBP_CONSTS_SVH
`define USBP_CONSTS_SVH

// register byte offsets from the i/o base
`define USBP_OFS_SOF      5'h0c
`define USBP_OFS_PORT1    5'h10
`define USBP_OFS_PORT2    5'h12
`define USBP_OFS_STEP     5'h02

// reset values
`define USBP_PORT_RST     16'h0000
`define USBP_SOF_RST      7'h40
`define USBP_SOF_BASE     14'h2ea0

// port register bit positions
`define USBP_B_SUSP       12
`define USBP_B_RST        9
`define USBP_B_LS         8
`define USBP_B_RES        6
`define USBP_B_LSHI       5
`define USBP_B_LSLO       4
`define USBP_B_ENCHG      3
`define USBP_B_EN         2
`define USBP_B_CCHG       1
`define USBP_B_CONN       0

// timing in native units, then cycles of the 100 ns clock
`define USBP_CLK_PS       100000
`define USBP_FS_BIT_PS    83333
`define USBP_LS_BIT_PS    666667
`define USBP_ATTACH_BITS  64
`define USBP_EOP_BITS     2
// the two synchroniser stages eat into the attach budget, so settle less
`define USBP_SYNC_STAGES  2
`define USBP_ATTACH_CYC \
    ((`USBP_ATTACH_BITS*`USBP_FS_BIT_PS)/`USBP_CLK_PS-`USBP_SYNC_STAGES)
`define USBP_EOP_CYC \
    ((`USBP_EOP_BITS*`USBP_LS_BIT_PS+`USBP_CLK_PS-1)/`USBP_CLK_PS)

`endif

// *** src/usbp_pkg.sv ***
// usbp_pkg: state structures of the root hub port block.
// assumes usbp_consts.svh supplies all numbers.
package usbp_pkg;

    // state of one downstream port
    typedef struct packed {
        logic       connect;    // current connect status
        logic       lowSpeed;   // low speed device seen at attach
        logic [1:0] lineSt;     // {d-, d+} latched at frame end
        logic       enable;     // port enabled
        logic       enChg;      // enable change, write one clears
        logic       conChg;     // connect change, write one clears
        logic       suspend;    // port actually suspended
        logic       suspPend;   // suspend asked, waiting on bus
        logic       resDet;     // resume detected or driven
        logic       portRst;    // port reset bit
        logic [7:0] eopCnt;     // low speed eop cycles left
        logic [7:0] debCnt;     // attach/detach settle counter
        logic       prevK;      // k state one cycle ago
        logic       driveSe0;   // drive single ended zero
        logic       driveK;     // drive resume k state
        logic       block;      // block downstream data
        logic       resumeEvt;  // pulse: resume wanted
    } usbp_port_s;

    // state of the top level
    typedef struct packed {
        logic [1:0]  dpMeta;    // first sync stage, d+
        logic [1:0]  dpSync;    // second sync stage, d+
        logic [1:0]  dmMeta;    // first sync stage, d-
        logic [1:0]  dmSync;    // second sync stage, d-
        logic [6:0]  sofVal;    // frame timing value
        logic [13:0] frameLen;  // length of the running frame
        logic [13:0] frameCnt;  // counter clocks in this frame
        logic        frameEnd;  // pulse at end of frame
        logic [15:0] rdData;    // registered read data
        logic        resumeReq; // resume request to controller
    } usbp_top_s;

endpackage

// *** src/usbp_port.sv ***
// usbp_port: status and control logic of one downstream port.
// assumes synchronised line levels and same-clock control inputs.
`timescale 1ns/100ps
`include "usbp_consts.svh"

module usbp_port #(
    parameter int ATTACH_CYC = `USBP_ATTACH_CYC,
    parameter int EOP_CYC    = `USBP_EOP_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register access
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    output      logic [15:0] regValue,
    // line and controller status
    input  wire logic        dp,
    input  wire logic        dm,
    input  wire logic        busy,
    input  wire logic        fault,
    input  wire logic        frameEnd,
    input  wire logic        globalSuspend,
    // line drive and events
    output      logic        driveSe0,
    output      logic        driveK,
    output      logic        blockData,
    output      logic        resumeEvt
);

    // counters are eight bits wide; bad counts refused at elaboration
    if (ATTACH_CYC < 1 || ATTACH_CYC > 255 ||
        EOP_CYC < 1 || EOP_CYC > 255)
    begin : g_bad_timing
        $error("usbp_port: timing count out of range");
    end

    usbp_pkg::usbp_port_s q, d;
    logic se0;
    logic kState;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        d         = q;
        se0       = !dp && !dm;
        // k polarity follows the attached device speed
        kState    = q.lowSpeed ? (dp && !dm) : (!dp && dm);
        d.prevK   = kState;
        // eop after resume: bit stays set until the eop ends;
        // counted first so a resume set in its last cycle wins
        if (q.eopCnt != 8'h00)
        begin
            d.eopCnt = q.eopCnt - 8'h01;
            if (q.eopCnt == 8'h01)
                d.resDet = 1'b0;
        end
        // software writes first, so hardware sets below win
        if (wrEn)
        begin
            d.portRst = wrData[`USBP_B_RST];
            d.enable  = wrData[`USBP_B_EN];
            if (wrData[`USBP_B_CCHG])
                d.conChg = 1'b0;
            if (wrData[`USBP_B_ENCHG])
                d.enChg = 1'b0;
            // suspend waits for the bus to go quiet
            if (wrData[`USBP_B_SUSP] && !q.suspend)
                d.suspPend = 1'b1;
            else if (!wrData[`USBP_B_SUSP])
            begin
                d.suspend  = 1'b0;
                d.suspPend = 1'b0;
            end
            if (wrData[`USBP_B_RES])
                d.resDet = 1'b1;
            else if (q.resDet && q.eopCnt == 8'h00)
                d.eopCnt = 8'(EOP_CYC);
        end
        // line level sampled only at frame end
        if (frameEnd)
            d.lineSt = {dm, dp};
        // attach and detach settle, skipped while we drive se0
        if ((se0 == q.connect) && !q.portRst && q.eopCnt == 8'h00)
        begin
            d.debCnt = q.debCnt + 8'h01;
            if (q.debCnt == 8'(ATTACH_CYC - 1))
            begin
                d.debCnt   = 8'h00;
                d.connect  = !se0;
                d.lowSpeed = !se0 && dm;
                d.conChg   = 1'b1;
                if (se0 && q.enable)
                begin
                    d.enable = 1'b0;
                    d.enChg  = 1'b1;
                end
            end
        end
        else
            d.debCnt = 8'h00;
        // other fault disables the port
        if (fault && q.enable)
        begin
            d.enable = 1'b0;
            d.enChg  = 1'b1;
        end
        // port reset forces disabled; stays so after release
        if (d.portRst)
        begin
            d.enable   = 1'b0;
            d.suspend  = 1'b0;
            d.suspPend = 1'b0;
        end
        // enter suspend once no transaction runs
        if (d.suspPend && !busy && d.enable)
        begin
            d.suspend  = 1'b1;
            d.suspPend = 1'b0;
        end
        // j to k while suspended marks a resume
        if (q.suspend && q.enable && kState && !q.prevK)
            d.resDet = 1'b1;
        // resume request when a status bit sets in global suspend
        d.resumeEvt = globalSuspend &&
            ((d.resDet && !q.resDet) || (d.enChg && !q.enChg) ||
             (d.conChg && !q.conChg));
        // line drive; se0 reset passes a suspended port
        d.driveSe0 = d.portRst || d.eopCnt != 8'h00;
        d.block    = d.suspend && d.enable;
        d.driveK   = d.resDet && d.block && d.eopCnt == 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    // reserved bits read zero, register assembled from flops
    assign regValue  = {3'h0, q.suspend, 2'h0, q.portRst, q.lowSpeed,
                        1'b0, q.resDet, q.lineSt, q.enChg, q.enable,
                        q.conChg, q.connect};
    assign driveSe0  = q.driveSe0;
    assign driveK    = q.driveK;
    assign blockData = q.block;
    assign resumeEvt = q.resumeEvt;

endmodule // usbp_port

// *** src/usbp_root_hub.sv ***
// usbp_root_hub: two port root hub status and control with the
// frame length register, reached over the controller's i/o window.
// assumes a 10 MHz clock, sofTick as a one-cycle enable at the
// frame counter rate, and busy/fault/suspend from same-clock logic.
`timescale 1ns/100ps
`include "usbp_consts.svh"

module usbp_root_hub #(
    parameter int NPORT      = 2,
    parameter int ATTACH_CYC = `USBP_ATTACH_CYC,
    parameter int EOP_CYC    = `USBP_EOP_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // i/o register access, byte offset from base
    input  wire logic [4:0]       ioAddr,
    input  wire logic             ioWr,
    input  wire logic             ioRd,
    input  wire logic [15:0]      ioWrData,
    output      logic [15:0]      ioRdData,
    // cable lines, asynchronous
    input  wire logic [NPORT-1:0] usbDp,
    input  wire logic [NPORT-1:0] usbDm,
    // controller side status
    input  wire logic [NPORT-1:0] linkBusy,
    input  wire logic [NPORT-1:0] portFault,
    input  wire logic             globalSuspend,
    input  wire logic             sofTick,
    // line drive per port
    output      logic [NPORT-1:0] portDriveSe0,
    output      logic [NPORT-1:0] portDriveK,
    output      logic [NPORT-1:0] portBlock,
    // controller events
    output      logic             resumeReq,
    output      logic             frameEnd
);

    // the map holds exactly two port registers; refused at elaboration
    if (NPORT != 2)
    begin : g_bad_nport
        $error("usbp_root_hub: only two ports are mapped");
    end

    ////////////////////////////////////////////////////////////////////
    // address decode, shared by write and read paths

    // true when addr hits the register of port idx
    function automatic logic portHit(input logic [4:0] addr,
                                     input int         idx);
        logic [4:0] base;
        base = `USBP_OFS_PORT1 + 5'(idx) * `USBP_OFS_STEP;
        return addr == base;
    endfunction

    usbp_pkg::usbp_top_s q, d;
    logic [NPORT-1:0]        portWr;     // write strobe per port
    logic [NPORT-1:0][15:0]  portVal;    // register value per port
    logic [NPORT-1:0]        portRes;    // resume pulse per port

    ////////////////////////////////////////////////////////////////////
    // per port logic
    generate
        for (genvar i = 0; i < NPORT; i++)
        begin : g_port
            // whole word writes only; no byte lanes exist
            assign portWr[i] = ioWr && portHit(ioAddr, i);
            usbp_port #(
                .ATTACH_CYC (ATTACH_CYC),
                .EOP_CYC    (EOP_CYC)
            ) u_port (
                .clk           (clk),
                .rst_b         (rst_b),
                .wrEn          (portWr[i]),
                .wrData        (ioWrData),
                .regValue      (portVal[i]),
                .dp            (q.dpSync[i]),
                .dm            (q.dmSync[i]),
                .busy          (linkBusy[i]),
                .fault         (portFault[i]),
                .frameEnd      (q.frameEnd),
                .globalSuspend (globalSuspend),
                .driveSe0      (portDriveSe0[i]),
                .driveK        (portDriveK[i]),
                .blockData     (portBlock[i]),
                .resumeEvt     (portRes[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // next state of top level
    always_comb
    begin
        d = q;
        // two stage synchronisers; meta stage read only here
        d.dpMeta = usbDp;
        d.dpSync = q.dpMeta;
        d.dmMeta = usbDm;
        d.dmSync = q.dmMeta;
        // frame timing value, low seven bits of the write
        if (ioWr && ioAddr == `USBP_OFS_SOF)
            d.sofVal = ioWrData[6:0];
        // frame counter; new length applies from next frame
        d.frameEnd = 1'b0;
        if (sofTick)
        begin
            if (q.frameCnt == q.frameLen - 14'h0001)
            begin
                d.frameCnt = 14'h0000;
                d.frameEnd = 1'b1;
                d.frameLen = `USBP_SOF_BASE + 14'(d.sofVal);
            end
            else
                d.frameCnt = q.frameCnt + 14'h0001;
        end
        // read data; unmapped offsets read zero
        if (ioRd)
        begin
            d.rdData = 16'h0000;
            if (ioAddr == `USBP_OFS_SOF)
                d.rdData = {9'h000, q.sofVal};
            for (int i = 0; i < NPORT; i++)
            begin
                if (portHit(ioAddr, i))
                    d.rdData = portVal[i];
            end
        end
        // resume request under global suspend
        d.resumeReq = |portRes;
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q          <= '0;
            q.sofVal   <= `USBP_SOF_RST;
            q.frameLen <= `USBP_SOF_BASE + 14'(`USBP_SOF_RST);
        end
        else
            q <= d;
    end

    // outputs straight from flops
    assign ioRdData  = q.rdData;
    assign resumeReq = q.resumeReq;
    assign frameEnd  = q.frameEnd;

endmodule // usbp_root_hub

// *** test/usbp_root_hub_checker.sv ***
// usbp_root_hub_checker: port level properties of the root hub.
// assumes it is bound onto usbp_root_hub with its own NPORT.
`timescale 1ns/100ps
module usbp_root_hub_checker #(
    parameter int NPORT = 2
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             rst_b,
    // register access
    input wire logic [4:0]       ioAddr,
    input wire logic             ioWr,
    input wire logic             ioRd,
    input wire logic [15:0]      ioWrData,
    input wire logic [15:0]      ioRdData,
    // controller and line side
    input wire logic             globalSuspend,
    input wire logic [NPORT-1:0] portDriveSe0,
    input wire logic [NPORT-1:0] portDriveK,
    input wire logic [NPORT-1:0] portBlock,
    input wire logic             resumeReq,
    input wire logic             frameEnd
);
    // one clock domain, so clocking and reset are set once
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////
    // register side
    a_read_hold: assert property (!ioRd |=> $stable(ioRdData))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        ioRd && !(ioAddr inside {5'h0c, 5'h10, 5'h12})
        |=> ioRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_port_rsvd: assert property (
        ioRd && (ioAddr == 5'h10 || ioAddr == 5'h12)
        |=> (ioRdData & 16'hec80) == 16'h0000)
        else $error("reserved port bits read nonzero");
    a_sof_width: assert property (
        ioRd && ioAddr == 5'h0c |=> ioRdData[15:7] == 9'h000)
        else $error("frame value wider than seven bits");

    ////////////////////////////////////////////////////////////////////
    // events and line drive
    a_resume_once: assert property (resumeReq |=> !resumeReq)
        else $error("resume request longer than one cycle");
    a_resume_cause: assert property (resumeReq |->
        globalSuspend || $past(globalSuspend) || $past(globalSuspend, 2))
        else $error("resume request outside global suspend");
    a_prst_se0: assert property (
        ioWr && ioAddr == 5'h10 && ioWrData[9]
        |-> ##[1:2] portDriveSe0[0])
        else $error("port reset without se0 drive");
    a_prst_noblk: assert property (
        ioWr && ioAddr == 5'h10 && ioWrData[9]
        |-> ##2 !portBlock[0] [*3])
        else $error("port in reset still blocking");
    a_k_suspended: assert property (
        ioWr && ioAddr == 5'h10 && ioWrData[12] && ioWrData[6] &&
        ioWrData[2] && !ioWrData[9] && portBlock[0] && !portDriveSe0[0]
        |=> portDriveK[0])
        else $error("forced resume not driven on suspended port");
    a_frame_pulse: assert property (frameEnd |=> !frameEnd)
        else $error("frame end longer than one cycle");
endmodule // usbp_root_hub_checker

bind usbp_root_hub usbp_root_hub_checker #(.NPORT(NPORT)) u_chk (.*);

// *** test/usbp_dev_model.sv ***
// usbp_dev_model: behavioural usb device on one downstream port.
// assumes host drive levels come as plain levels; no clock needed.
`timescale 1ns/100ps
module usbp_dev_model (
    // bench commands
    input  wire logic attached, // cable plugged in
    input  wire logic lowSpeed, // pull-up on d- instead of d+
    input  wire logic sendK,    // device signals resume
    // host drive
    input  wire logic hostSe0,
    input  wire logic hostK,
    // resolved cable lines
    output      logic dp,
    output      logic dm
);
    // host drive wins over the weak device pull-up
    always_comb
    begin
        if (hostSe0)
            {dp, dm} = 2'b00;
        else if (hostK || sendK)
            {dp, dm} = {lowSpeed, !lowSpeed}; // k is j inverted
        else if (attached)
            {dp, dm} = {!lowSpeed, lowSpeed};
        else
            {dp, dm} = 2'b00; // host pull-downs give se0 unplugged
    end
endmodule // usbp_dev_model

// *** test/testbench.sv ***
// testbench: directed checks of the root hub port block.
// assumes the checker is bound in; small attach and eop counts.
`timescale 1ns/100ps
module testbench;
    localparam int ATT = 4;
    logic clk = 0, rst_b = 0, ioWr = 0, ioRd = 0;
    logic [4:0] ioAddr = 5'h00;
    logic [15:0] ioWrData = 16'h0000, ioRdData;
    wire logic [1:0] usbDp, usbDm;
    logic [1:0] linkBusy = 0, portFault = 0, attached = 0;
    logic [1:0] lowSpd = 0, sendK = 0, portDriveSe0, portDriveK, portBlock;
    logic globalSuspend = 0, sofTick = 0, resumeReq, frameEnd;
    int errorCnt = 0, cmpCount = 0, resumeCnt = 0, n;

    always #50 clk = ~clk;
    // count resume request pulses where they have settled
    always @(negedge clk)
        if (resumeReq === 1'b1)
            resumeCnt++;

    usbp_root_hub #(.NPORT(2), .ATTACH_CYC(ATT), .EOP_CYC(2))
        usbp_root_hub_inst (.*);
    for (genvar i = 0; i < 2; i++)
    begin : g_dev
        usbp_dev_model usbp_dev_model_inst (.attached(attached[i]),
            .lowSpeed(lowSpd[i]), .sendK(sendK[i]),
            .hostSe0(portDriveSe0[i]), .hostK(portDriveK[i]),
            .dp(usbDp[i]), .dm(usbDm[i]));
    end

    ////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        ioAddr = a;
        // port words keep the reserved top bits at zero
        ioWrData = (a == 5'h10 || a == 5'h12) ? (d & 16'h1fff) : d;
        ioWr = 1'b1;
        @(negedge clk);
        ioWr = 1'b0;
    endtask
    // read, mask and compare one word
    task automatic rdc(input logic [4:0] a, input logic [15:0] m,
                       input logic [15:0] exp);
        @(negedge clk);
        ioAddr = a;
        ioRd = 1'b1;
        @(negedge clk);
        ioRd = 1'b0;
        chk(ioRdData & m, exp);
    endtask
    task automatic wait_fe(output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (frameEnd !== 1'b1 && k < 13000);
    endtask
    task automatic give_verdict;
        $display("errors %0d compares %0d", errorCnt, cmpCount);
        if (errorCnt == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rdc(5'h10, 16'hffff, 16'h0000);
        rdc(5'h12, 16'hffff, 16'h0000);
        rdc(5'h0c, 16'hffff, 16'h0040);
        wr(5'h0e, 16'h1fff);
        rdc(5'h0e, 16'hffff, 16'h0000);
    endtask
    task automatic t_attach;
        attached[0] = 1'b1;
        cyc(ATT + 5);
        rdc(5'h10, 16'hffff, 16'h0003);
        wr(5'h10, 16'h0006); // enable, clear connect change
        rdc(5'h10, 16'hffff, 16'h0005);
    endtask
    // suspend waits for the running transaction
    task automatic t_suspend;
        linkBusy[0] = 1'b1;
        wr(5'h10, 16'h1004);
        cyc(3);
        rdc(5'h10, 16'hffff, 16'h0005);
        chk(portBlock[0], 1'b0);
        linkBusy[0] = 1'b0;
        cyc(3);
        rdc(5'h10, 16'hffff, 16'h1005);
        chk(portBlock[0], 1'b1);
    endtask
    task automatic t_resume;
        globalSuspend = 1'b1; // port suspended beforehand
        sendK[0] = 1'b1;
        cyc(6);
        sendK[0] = 1'b0;
        rdc(5'h10, 16'hffff, 16'h1045);
        chk(resumeCnt, 1);
        chk(portDriveK[0], 1'b1);
        wr(5'h10, 16'h1004); // resume bit to zero starts eop
        cyc(8);
        rdc(5'h10, 16'h0040, 16'h0000);
        wr(5'h10, 16'h1044); // software forces resume while suspended
        chk(portDriveK[0], 1'b1);
        wr(5'h10, 16'h1004); // second eop
        cyc(8);
        rdc(5'h10, 16'h0040, 16'h0000);
        wr(5'h10, 16'h0004); // leave suspend
        attached[0] = 1'b0;
        cyc(ATT + 5);
        rdc(5'h10, 16'hffff, 16'h000a);
        chk(resumeCnt, 3);
        globalSuspend = 1'b0;
        wr(5'h10, 16'h000a);
    endtask
    task automatic t_port_reset;
        attached[0] = 1'b1;
        cyc(ATT + 5);
        wr(5'h10, 16'h0006);
        wr(5'h10, 16'h1204); // reset wins over enable and suspend
        cyc(2);
        rdc(5'h10, 16'h1204, 16'h0200);
        chk(portDriveSe0[0], 1'b1);
        wr(5'h10, 16'h0000); // software times the reset
        cyc(10);
        rdc(5'h10, 16'h0204, 16'h0000);
        chk(portDriveSe0[0], 1'b0);
    endtask
    task automatic t_fault;
        lowSpd[1] = 1'b1;
        attached[1] = 1'b1;
        cyc(ATT + 5);
        wr(5'h12, 16'h0006);
        rdc(5'h12, 16'hffff, 16'h0105);
        portFault[1] = 1'b1;
        cyc(3);
        portFault[1] = 1'b0;
        rdc(5'h12, 16'hffff, 16'h0109);
    endtask
    // new value only applies from the next frame
    task automatic t_frame;
        sofTick = 1'b1;
        wr(5'h0c, 16'h0000);
        wait_fe(n);
        wait_fe(n);
        chk(n, 11936);
        wr(5'h0c, 16'h007f);
        wait_fe(n);
        wait_fe(n);
        chk(n, 12063);
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_attach();
        t_suspend();
        t_resume();
        t_port_reset();
        t_fault();
        t_frame();
        give_verdict();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        give_verdict();
    end
endmodule // testbench
